// [pkg/pcm_port_map.vh]
`ifndef PCM_PORT_MAP_VH
`define PCM_PORT_MAP_VH
// Register word indices on the plain register port.
`define ADDR_TX_CFG 4'h0
`define ADDR_RX_CFG 4'h1
`define ADDR_CTRL 4'h2
`define ADDR_TX_SAMPLE 4'h3
`define ADDR_RX_SAMPLE 4'h4
`define ADDR_STATUS 4'h5
// Direction configuration fields: slot number, port select, delayed mode.
`define CFG_SLOT_LSB 0
`define CFG_SLOT_MSB 5
`define CFG_PORT_BIT 6
`define CFG_DELAYED_BIT 7
// Control fields.
`define CTRL_POWER_UP_BIT 0
`define CTRL_ALAW_BIT 1
// Reset values: powered down, non-delayed, slot 0, port 0, mu-law.
`define TX_CFG_RESET 8'h00
`define RX_CFG_RESET 8'h00
`define CTRL_RESET 8'h00
// Bits of a PCM sample.
`define SAMPLE_BITS 8
`endif

// [logic/sample_fifo.v]
`timescale 1ns/10ps
// Small synchronous FIFO with valid and ready on both sides.
module sample_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire reset,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0] count_r;
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  wire push;
  wire pop;

  // Honest full and empty flags from the occupancy count.
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers and count.
  always @(posedge clk) begin
    if (reset) begin
      count_r <= {(AW+1){1'b0}};
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == DEPTH - 1) ? {AW{1'b0}} : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == DEPTH - 1) ? {AW{1'b0}} : rptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // Storage write.
  always @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  // Read data comes from a register that shows the head word.
  always @(posedge clk) begin
    if (reset) begin
      out_data <= {WIDTH{1'b0}};
    end else if (pop && count_r > 1) begin
      out_data <= mem_r[(rptr_r == DEPTH - 1) ? {AW{1'b0}} : rptr_r + 1'b1];
    end else if (push && (count_r == 0 || (pop && count_r == 1))) begin
      out_data <= in_data;
    end
  end
endmodule

// [logic/pcm_timeslot_serial_port.v]
`timescale 1ns/10ps
`include "pcm_port_map.vh"
module pcm_timeslot_serial_port #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire bit_clock,
  input wire transmit_frame_sync,
  input wire receive_frame_sync,
  output reg transmit_data_port0_out,
  output reg transmit_data_port0_oe_n,
  output reg transmit_data_port1_out,
  output reg transmit_data_port1_oe_n,
  output wire transmit_slot_indicator0_out,
  output reg transmit_slot_indicator0_oe_n,
  output wire transmit_slot_indicator1_out,
  output reg transmit_slot_indicator1_oe_n,
  input wire receive_data_port0,
  input wire receive_data_port1,
  input wire [7:0] transmit_voice_input,
  input wire transmit_voice_valid,
  output wire transmit_voice_ready,
  output reg [7:0] receive_voice_output,
  output reg receive_voice_strobe
);
  localparam ST_IDLE = 3'b001;
  localparam ST_COUNT = 3'b010;
  localparam ST_SHIFT = 3'b100;

  reg [7:0] tx_cfg_r;
  reg [7:0] rx_cfg_r;
  reg [7:0] ctrl_r;
  reg [1:0] bclk_sync_r;
  reg [1:0] fsx_sync_r;
  reg [1:0] fsr_sync_r;
  reg [1:0] dr0_sync_r;
  reg [1:0] dr1_sync_r;
  reg bclk_prev_r;
  reg fsx_prev_r;
  reg fsr_prev_r;
  reg [2:0] tx_state_r;
  reg [2:0] tx_state_nxt;
  reg [2:0] rx_state_r;
  reg [2:0] rx_state_nxt;
  reg [8:0] tx_cnt_r;
  reg [8:0] rx_cnt_r;
  reg [7:0] tx_shift_r;
  reg [7:0] rx_shift_r;
  reg tx_pending_r;
  reg rx_pending_r;
  reg [7:0] tx_sample_r;
  reg [7:0] rx_sample_r;
  reg tx_underrun_r;
  reg rx_overrun_r;
  reg tx_port_r;
  wire bclk_rise;
  wire bclk_fall;
  wire fsx_rise;
  wire fsr_rise;
  wire powered;
  wire rx_bit;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;

  // Slot start offset in bit clocks for a configuration: slot number times eight.
  function [8:0] slot_start;
    input [7:0] cfg;
    begin
      slot_start = {cfg[`CFG_SLOT_MSB:`CFG_SLOT_LSB], 3'b000};
    end
  endfunction

  assign powered = ctrl_r[`CTRL_POWER_UP_BIT];

  // Two-flip-flop synchronisers for every pin input, then edge history.
  always @(posedge clk) begin
    if (reset) begin
      bclk_sync_r <= 2'h0;
      fsx_sync_r <= 2'h0;
      fsr_sync_r <= 2'h0;
      dr0_sync_r <= 2'h0;
      dr1_sync_r <= 2'h0;
      bclk_prev_r <= 1'b0;
      fsx_prev_r <= 1'b0;
      fsr_prev_r <= 1'b0;
    end else begin
      bclk_sync_r <= {bclk_sync_r[0], bit_clock};
      fsx_sync_r <= {fsx_sync_r[0], transmit_frame_sync};
      fsr_sync_r <= {fsr_sync_r[0], receive_frame_sync};
      dr0_sync_r <= {dr0_sync_r[0], receive_data_port0};
      dr1_sync_r <= {dr1_sync_r[0], receive_data_port1};
      bclk_prev_r <= bclk_sync_r[1];
      fsx_prev_r <= fsx_sync_r[1];
      fsr_prev_r <= fsr_sync_r[1];
    end
  end

  assign bclk_rise = bclk_sync_r[1] && !bclk_prev_r;
  assign bclk_fall = !bclk_sync_r[1] && bclk_prev_r;
  assign fsx_rise = fsx_sync_r[1] && !fsx_prev_r;
  assign fsr_rise = fsr_sync_r[1] && !fsr_prev_r;
  // Only the programmed receive port is looked at.
  assign rx_bit = rx_cfg_r[`CFG_PORT_BIT] ? dr1_sync_r[1] : dr0_sync_r[1];

  // Transmit samples wait in a small FIFO; a frame takes one per slot.
  sample_fifo #(
    .WIDTH(`SAMPLE_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) tx_fifo (
    .clk(clk),
    .reset(reset),
    .in_data(transmit_voice_input),
    .in_valid(transmit_voice_valid),
    .in_ready(transmit_voice_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // A sample is drawn at each transmit frame sync while powered and the FIFO is not empty.
  assign fifo_pop = fsx_rise && powered && fifo_valid;

  // Register writes; reset leaves the port powered down and non-delayed.
  always @(posedge clk) begin
    if (reset) begin
      tx_cfg_r <= `TX_CFG_RESET;
      rx_cfg_r <= `RX_CFG_RESET;
      ctrl_r <= `CTRL_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        `ADDR_TX_CFG: tx_cfg_r <= reg_wdata;
        `ADDR_RX_CFG: rx_cfg_r <= reg_wdata;
        `ADDR_CTRL: ctrl_r <= reg_wdata;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Register reads answer one cycle later; unmapped words read zero.
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `ADDR_TX_CFG: reg_rdata <= tx_cfg_r;
        `ADDR_RX_CFG: reg_rdata <= rx_cfg_r;
        `ADDR_CTRL: reg_rdata <= ctrl_r;
        `ADDR_TX_SAMPLE: reg_rdata <= tx_sample_r;
        `ADDR_RX_SAMPLE: reg_rdata <= rx_sample_r;
        `ADDR_STATUS: reg_rdata <= {4'h0, rx_overrun_r, tx_underrun_r,
                                    rx_state_r == ST_SHIFT, tx_state_r == ST_SHIFT};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Transmit sequencer next state.
  always @* begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      ST_IDLE: begin
        if (fsx_rise && powered) begin
          if (!tx_cfg_r[`CFG_DELAYED_BIT] || slot_start(tx_cfg_r) == 9'h000) begin
            tx_state_nxt = ST_SHIFT;
          end else begin
            tx_state_nxt = ST_COUNT;
          end
        end
      end
      ST_COUNT: begin
        if (!powered) begin
          tx_state_nxt = ST_IDLE;
        end else if (bclk_rise && tx_cnt_r == slot_start(tx_cfg_r) - 9'h001) begin
          tx_state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!powered || (bclk_rise && tx_cnt_r == 9'h008)) begin
          tx_state_nxt = ST_IDLE;
        end
      end
      default: tx_state_nxt = ST_IDLE;
    endcase
  end

  // Transmit counters and shifting; each rising bit clock presents one bit.
  always @(posedge clk) begin
    if (reset) begin
      tx_state_r <= ST_IDLE;
      tx_cnt_r <= 9'h000;
      tx_shift_r <= 8'h00;
      tx_pending_r <= 1'b0;
      tx_sample_r <= 8'h00;
      tx_underrun_r <= 1'b0;
      tx_port_r <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      if (fsx_rise && powered) begin
        tx_cnt_r <= 9'h000;
        tx_pending_r <= 1'b1;
        tx_port_r <= tx_cfg_r[`CFG_PORT_BIT];
        tx_sample_r <= fifo_valid ? fifo_data : tx_sample_r;
        tx_shift_r <= fifo_valid ? fifo_data : tx_sample_r;
        tx_underrun_r <= !fifo_valid;
      end else if (bclk_rise && tx_state_r != ST_IDLE) begin
        tx_cnt_r <= (tx_state_r == ST_SHIFT && tx_state_nxt == ST_COUNT) ? 9'h000
                    : (tx_state_r == ST_COUNT && tx_state_nxt == ST_SHIFT) ? 9'h000
                    : tx_cnt_r + 9'h001;
        if (tx_state_r == ST_SHIFT) begin
          if (tx_pending_r) begin
            tx_pending_r <= 1'b0;
          end else begin
            tx_shift_r <= {tx_shift_r[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Drive pins: data and indicator only on the selected port in the slot.
  always @(posedge clk) begin
    if (reset) begin
      transmit_data_port0_out <= 1'b0;
      transmit_data_port1_out <= 1'b0;
      transmit_data_port0_oe_n <= 1'b1;
      transmit_data_port1_oe_n <= 1'b1;
      transmit_slot_indicator0_oe_n <= 1'b1;
      transmit_slot_indicator1_oe_n <= 1'b1;
    end else begin
      transmit_data_port0_out <= tx_shift_r[7];
      transmit_data_port1_out <= tx_shift_r[7];
      transmit_data_port0_oe_n <= !(tx_state_r == ST_SHIFT && !tx_pending_r && !tx_port_r);
      transmit_data_port1_oe_n <= !(tx_state_r == ST_SHIFT && !tx_pending_r && tx_port_r);
      transmit_slot_indicator0_oe_n <= !(tx_state_r == ST_SHIFT && !tx_pending_r && !tx_port_r);
      transmit_slot_indicator1_oe_n <= !(tx_state_r == ST_SHIFT && !tx_pending_r && tx_port_r);
    end
  end

  // Open-drain indicators only ever pull low.
  assign transmit_slot_indicator0_out = 1'b0;
  assign transmit_slot_indicator1_out = 1'b0;

  // Receive sequencer next state.
  always @* begin
    rx_state_nxt = rx_state_r;
    case (rx_state_r)
      ST_IDLE: begin
        if (fsr_rise && powered) begin
          if (!rx_cfg_r[`CFG_DELAYED_BIT] || slot_start(rx_cfg_r) == 9'h000) begin
            rx_state_nxt = ST_SHIFT;
          end else begin
            rx_state_nxt = ST_COUNT;
          end
        end
      end
      ST_COUNT: begin
        if (!powered) begin
          rx_state_nxt = ST_IDLE;
        end else if (bclk_fall && rx_cnt_r == slot_start(rx_cfg_r) - 9'h001) begin
          rx_state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!powered || (bclk_fall && rx_cnt_r == 9'h007)) begin
          rx_state_nxt = ST_IDLE;
        end
      end
      default: rx_state_nxt = ST_IDLE;
    endcase
  end

  // Receive counting and capture on falling bit clock edges.
  always @(posedge clk) begin
    if (reset) begin
      rx_state_r <= ST_IDLE;
      rx_cnt_r <= 9'h000;
      rx_shift_r <= 8'h00;
      rx_pending_r <= 1'b0;
      rx_sample_r <= 8'h00;
      rx_overrun_r <= 1'b0;
      receive_voice_output <= 8'h00;
      receive_voice_strobe <= 1'b0;
    end else begin
      rx_state_r <= rx_state_nxt;
      receive_voice_strobe <= 1'b0;
      if (fsr_rise && powered) begin
        rx_cnt_r <= 9'h000;
        rx_overrun_r <= rx_pending_r;
        rx_pending_r <= 1'b1;
      end else if (bclk_fall && rx_state_r != ST_IDLE) begin
        rx_cnt_r <= (rx_state_r == ST_COUNT && rx_state_nxt == ST_SHIFT) ? 9'h000
                    : rx_cnt_r + 9'h001;
        if (rx_state_r == ST_SHIFT) begin
          rx_shift_r <= {rx_shift_r[6:0], rx_bit};
          if (rx_cnt_r == 9'h007) begin
            rx_sample_r <= {rx_shift_r[6:0], rx_bit};
            receive_voice_output <= {rx_shift_r[6:0], rx_bit};
            receive_voice_strobe <= 1'b1;
            rx_pending_r <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// [test/pcm_timeslot_serial_port_asserts.sv]
`timescale 1ns/10ps
`include "pcm_port_map.vh"
module pcm_timeslot_serial_port_asserts (
  input wire clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire transmit_data_port0_out,
  input wire transmit_data_port0_oe_n,
  input wire transmit_data_port1_oe_n,
  input wire transmit_slot_indicator0_out,
  input wire transmit_slot_indicator0_oe_n,
  input wire transmit_slot_indicator1_out,
  input wire transmit_slot_indicator1_oe_n,
  input wire receive_voice_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  reg powered_r;
  reg [7:0] low_cnt_r;
  wire both_off = transmit_data_port0_oe_n & transmit_data_port1_oe_n;
  // Mirrors the power-up bit so that quiet outputs can be demanded while powered down.
  always @(posedge clk) begin
    if (reset) powered_r <= 1'b0;
    else if (reg_write && reg_addr == `ADDR_CTRL) powered_r <= reg_wdata[`CTRL_POWER_UP_BIT];
  end
  // Counts the cycles for which a transmit output has been driven.
  always @(posedge clk) begin
    if (reset || both_off) low_cnt_r <= 8'h00;
    else low_cnt_r <= low_cnt_r + 8'h01;
  end
  sequence s_bit_launch;
    $changed(transmit_data_port0_out) && !transmit_data_port0_oe_n;
  endsequence
  sequence s_bit_hold;
    $stable(transmit_data_port0_out) [*5];
  endsequence
  a_bit_holds_period: assert property (s_bit_launch |=> s_bit_hold)
    else $error("transmit bit changed within one bit period");
  a_slot_eight_bits: assert property ($rose(both_off) |-> low_cnt_r >= 8'h3e && low_cnt_r <= 8'h42)
    else $error("transmit slot length is not eight bit periods");
  a_one_port_only: assert property (transmit_data_port0_oe_n || transmit_data_port1_oe_n)
    else $error("both transmit ports driven at once");
  a_ind0_tracks_data: assert property (transmit_slot_indicator0_oe_n == transmit_data_port0_oe_n)
    else $error("slot indicator 0 does not follow its data port");
  a_ind1_tracks_data: assert property (transmit_slot_indicator1_oe_n == transmit_data_port1_oe_n)
    else $error("slot indicator 1 does not follow its data port");
  a_ind_pulls_low: assert property (!transmit_slot_indicator0_out && !transmit_slot_indicator1_out)
    else $error("slot indicator drives high");
  a_quiet_powered_down: assert property (!powered_r && !$past(powered_r)
    && !$past(powered_r, 2) |-> both_off)
    else $error("transmit port driven while powered down");
  a_voice_strobe_pulse: assert property (receive_voice_strobe |=> !receive_voice_strobe)
    else $error("decoded byte strobe longer than one cycle");
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
endmodule
bind pcm_timeslot_serial_port pcm_timeslot_serial_port_asserts chk (.clk, .reset, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .transmit_data_port0_out,
  .transmit_data_port0_oe_n, .transmit_data_port1_oe_n, .transmit_slot_indicator0_out,
  .transmit_slot_indicator0_oe_n, .transmit_slot_indicator1_out,
  .transmit_slot_indicator1_oe_n, .receive_voice_strobe);

// [test/pcm_highway_model.sv]
`timescale 1ns/10ps
module pcm_highway_model (
  output logic bit_clock,
  output logic transmit_frame_sync,
  output logic receive_frame_sync,
  output logic receive_data_port0,
  output logic receive_data_port1,
  input wire logic tx0,
  input wire logic ind0,
  input wire logic tx1,
  input wire logic ind1
);
  logic [7:0] cap0, cap1, rxb;
  logic rport, bitv;
  int n0, n1, rslot, k;
  // Bit clock of eight master clocks, so it stays synchronous at a fixed phase.
  initial begin
    {transmit_frame_sync, receive_frame_sync, receive_data_port0, receive_data_port1} = 4'h0;
    k = 99;
    rslot = 0;
    bit_clock = 0;
    #13;
    forever #40 bit_clock = ~bit_clock;
  end
  // Captures driven slots and launches receive bits so they stand around falling edges.
  always @(posedge bit_clock) begin
    k = k + 1;
    if (ind0 == 1'b0) begin cap0 = {cap0[6:0], tx0}; n0++; end
    if (ind1 == 1'b0) begin cap1 = {cap1[6:0], tx1}; n1++; end
    if (k > 8 * rslot && k <= 8 * rslot + 8) begin
      bitv = rxb[8 * rslot + 8 - k];
      receive_data_port0 = rport ? ~bitv : bitv;
      receive_data_port1 = rport ? bitv : ~bitv;
    end else begin
      receive_data_port0 = k[0];
      receive_data_port1 = ~k[0];
    end
  end
  // One short frame: both syncs for one bit period, then forty bit clocks, enough for slot 2.
  task automatic frame(input logic [7:0] b, input logic p, input int s);
    @(negedge bit_clock);
    {rxb, rport, rslot, k, n0, n1, cap0, cap1} = {b, p, s, 32'd0, 32'd0, 32'd0, 16'h0000};
    transmit_frame_sync = 1;
    receive_frame_sync = 1;
    @(negedge bit_clock);
    transmit_frame_sync = 0;
    receive_frame_sync = 0;
    repeat (40) @(negedge bit_clock);
  endtask
endmodule

// [test/pcm_timeslot_serial_port_tb_top.sv]
`timescale 1ns/10ps
`include "pcm_port_map.vh"
module pcm_timeslot_serial_port_tb_top;
  logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, transmit_voice_valid = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, transmit_voice_input = 8'h00, rx_last = 8'h00;
  wire [7:0] reg_rdata, receive_voice_output;
  wire bit_clock, transmit_frame_sync, receive_frame_sync, receive_data_port0, receive_data_port1;
  wire transmit_voice_ready, receive_voice_strobe, transmit_data_port0_out, transmit_data_port1_out;
  wire transmit_data_port0_oe_n, transmit_data_port1_oe_n, transmit_slot_indicator0_out;
  wire transmit_slot_indicator1_out, transmit_slot_indicator0_oe_n, transmit_slot_indicator1_oe_n;
  int errors = 0, comparisons = 0, cyc = 0;
  // Released data lines show a changing pattern; indicator lines have pull-ups.
  wire line0 = transmit_data_port0_oe_n ? cyc[0] : transmit_data_port0_out;
  wire line1 = transmit_data_port1_oe_n ? ~cyc[0] : transmit_data_port1_out;
  wire sel0 = transmit_slot_indicator0_oe_n ? 1'b1 : transmit_slot_indicator0_out;
  wire sel1 = transmit_slot_indicator1_oe_n ? 1'b1 : transmit_slot_indicator1_out;
  always #5 clk = ~clk;
  pcm_timeslot_serial_port dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .bit_clock, .transmit_frame_sync, .receive_frame_sync, .transmit_data_port0_out,
    .transmit_data_port0_oe_n, .transmit_data_port1_out, .transmit_data_port1_oe_n,
    .transmit_slot_indicator0_out, .transmit_slot_indicator0_oe_n, .transmit_slot_indicator1_out,
    .transmit_slot_indicator1_oe_n, .receive_data_port0, .receive_data_port1,
    .transmit_voice_input, .transmit_voice_valid, .transmit_voice_ready, .receive_voice_output,
    .receive_voice_strobe);
  pcm_highway_model hw (.bit_clock, .transmit_frame_sync, .receive_frame_sync,
    .receive_data_port0, .receive_data_port1, .tx0(line0), .ind0(sel0), .tx1(line1), .ind1(sel1));
  // Records each decoded byte when it is handed on.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (receive_voice_strobe === 1'b1) rx_last <= receive_voice_output;
  end
  task automatic report_and_stop;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One register access, then one idle cycle; a read compares its answer.
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, exp);
    @(posedge clk);
    reg_write <= w;
    reg_read <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 0;
    reg_read <= 0;
    @(posedge clk);
    if (!w) check(reg_rdata, exp);
  endtask
  task automatic push(input logic [7:0] v);
    @(posedge clk);
    transmit_voice_input <= v;
    transmit_voice_valid <= 1;
    @(posedge clk);
    for (int i = 0; i < 50 && transmit_voice_ready !== 1'b1; i++) @(posedge clk);
    transmit_voice_valid <= 0;
    @(posedge clk);
  endtask
  // Gives up long after the expected run of eight frames.
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    acc(0, `ADDR_TX_CFG, 0, `TX_CFG_RESET);
    acc(0, `ADDR_RX_CFG, 0, `RX_CFG_RESET);
    acc(0, `ADDR_CTRL, 0, `CTRL_RESET);
    acc(0, 4'hf, 0, 8'h00);
    hw.frame(8'h5a, 0, 0);
    check(8'(hw.n0 + hw.n1), 8'h00);
    acc(1, `ADDR_CTRL, 8'h01, 0);
    push(8'ha5);
    hw.frame(8'h96, 0, 0);
    check(hw.cap0, 8'ha5);
    check(8'(hw.n0 * 16 + hw.n1), 8'h80);
    check(rx_last, 8'h96);
    acc(1, `ADDR_TX_CFG, 8'hc2, 0);
    acc(1, `ADDR_RX_CFG, 8'hc1, 0);
    acc(0, `ADDR_TX_CFG, 0, 8'hc2);
    push(8'h3c);
    hw.frame(8'h69, 1, 1);
    check(hw.cap1, 8'h3c);
    check(8'(hw.n0 * 16 + hw.n1), 8'h08);
    check(rx_last, 8'h69);
    for (int i = 0; i < 4; i++) push(8'h10 + 8'(i));
    check({7'h00, transmit_voice_ready}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      hw.frame(8'hf0 + 8'(i), 1, 1);
      check(hw.cap1, 8'h10 + 8'(i));
      check(rx_last, 8'hf0 + 8'(i));
    end
    check({7'h00, transmit_voice_ready}, 8'h01);
    hw.frame(8'h77, 1, 1);
    check(hw.cap1, 8'h13);
    check(rx_last, 8'h77);
    acc(1, `ADDR_TX_SAMPLE, 8'hff, 0);
    acc(0, `ADDR_TX_SAMPLE, 0, 8'h13);
    acc(0, `ADDR_RX_SAMPLE, 0, 8'h77);
    acc(0, `ADDR_STATUS, 0, 8'h04);
    acc(1, `ADDR_CTRL, 8'h03, 0);
    acc(0, `ADDR_CTRL, 0, 8'h03);
    report_and_stop();
  end
endmodule
